// file: core/loop_srq_cfg.svh
// constants for the loop service-request and poll-response block
// assumes a single 25 MHz clock and an active-low asynchronous reset
`ifndef LOOP_SRQ_CFG_SVH
`define LOOP_SRQ_CFG_SVH
// ============================================================
// enable register layout, plus status byte and poll code bit positions
`define MASTER_EN_BIT       3
`define COND_COUNT          24
`define CLOSED_DEFAULT      24'h000000
`define OPEN_DEFAULT        24'h06040c
`define SYS_STATUS_SRQ_BIT  6
`define PPOLL_SENSE_BIT     3
`endif

// file: core/loop_srq_pkg.sv
// types shared by the loop service-request block
// assumes the constants header is included ahead of it
`include "loop_srq_cfg.svh"
package loop_srq_pkg;
  // ============================================================
  // frame kinds seen on the loop
  typedef enum logic [2:0] {
    FR_DATA     = 3'h0,
    FR_END      = 3'h1,
    FR_IDENTIFY = 3'h2,
    FR_CMD      = 3'h3,
    FR_OTHER    = 3'h4
  } frame_kind_t;

  typedef struct packed {
    frame_kind_t kind;
    logic        srq;
    logic [7:0]  data;
  } frame_t;

  // decoded loop commands reaching this block
  typedef struct packed {
    logic       universal;
    logic       enableAsync;
    logic       powerDown;
    logic       ppEnable;
    logic [3:0] ppCode;
    logic       ppUnconfig;
    logic       ppDisable;
    logic       sendStatusDone;
  } loop_cmd_t;

  typedef enum logic [1:0] {
    ID_IDLE = 2'b00,
    ID_SEND = 2'b01,
    ID_WAIT = 2'b11
  } id_state_t;
endpackage

// file: core/loop_srq.sv
// service-request marking, idle-loop identify and poll response
// assumes frames arrive decoded, one per cycle with inValid, and the
// outgoing port holds the frame until outReady
`timescale 1ns/1ns
`include "loop_srq_cfg.svh"
module loop_srq
  import loop_srq_pkg::*;
#(
  parameter logic [`COND_COUNT-1:0] OPEN_DEFAULT = `OPEN_DEFAULT
) (
  input  wire logic                   clock,
  input  wire logic                   rstn,
  input  wire logic                   switchOpen,
  input  wire logic                   manualRequestKey,
  input  wire logic [`COND_COUNT-1:0] statusCond,
  input  wire logic                   enWrite,
  input  wire logic [`COND_COUNT-1:0] enWriteData,
  input  wire loop_cmd_t              cmd,
  input  wire logic                   listenerAddressed,
  input  wire logic                   loopIdle,
  input  wire logic                   inValid,
  input  wire frame_t                 inFrame,
  output frame_t                      outFrame,
  output logic                        outValid,
  input  wire logic                   outReady,
  output logic [`COND_COUNT-1:0]      requestEnable,
  output logic                        asyncEnable,
  output logic                        sysStatusSrq,
  output logic                        ppConfigured
);
  // ============================================================
  // enable registers
  // the strap is read once, on the first edge after reset release,
  // so a switch that moves later leaves run-time writes alone
  logic [`COND_COUNT-1:0] en_q;
  logic                   strapDone_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      en_q        <= `CLOSED_DEFAULT;
      strapDone_q <= 1'b0;
    end else if (!strapDone_q) begin
      strapDone_q <= 1'b1;
      if (switchOpen) begin
        en_q <= OPEN_DEFAULT;
      end else begin
        en_q <= `CLOSED_DEFAULT;
      end
    end else if (enWrite) begin
      en_q <= enWriteData;
    end
  end

  assign requestEnable = en_q;

  // ============================================================
  // request source
  logic                   keyHeld_q;
  logic                   keyFlag_q;
  logic                   keyPress;
  logic                   keyPending;
  logic [`COND_COUNT-1:0] condPrev_q;
  logic                   srq_q;
  logic                   condHit;
  logic                   condChange;
  logic                   masterOn;

  assign masterOn   = en_q[`MASTER_EN_BIT];
  assign keyPress   = manualRequestKey && !keyHeld_q;
  // a key flag that status sent is clearing no longer requests,
  // otherwise the request would outlive the status it reported
  assign keyPending = keyFlag_q && !cmd.sendStatusDone;
  assign condHit    = |(statusCond & en_q);
  assign condChange = |((statusCond ^ condPrev_q) & en_q);

  // key flag: set on a press, cleared once status has been sent
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      keyHeld_q <= 1'b0;
      keyFlag_q <= 1'b0;
    end else begin
      keyHeld_q <= manualRequestKey;
      if (keyPress) begin
        keyFlag_q <= 1'b1;
      end else if (cmd.sendStatusDone) begin
        keyFlag_q <= 1'b0;
      end
    end
  end

  // request flag, shown as status bit of the system status byte
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      condPrev_q <= '0;
      srq_q      <= 1'b0;
    end else begin
      condPrev_q <= statusCond;
      if (!masterOn) begin
        srq_q <= 1'b0;
      end else if (keyPending) begin
        srq_q <= 1'b1;
      end else if (condHit && !srq_q && condChange) begin
        srq_q <= 1'b1;
      end else if (cmd.sendStatusDone) begin
        srq_q <= 1'b0;
      end else if (condChange && !condHit) begin
        srq_q <= 1'b0;
      end
    end
  end

  assign sysStatusSrq = srq_q;

  // ============================================================
  // asynchronous request enable
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      asyncEnable <= 1'b0;
    end else if (cmd.enableAsync) begin
      asyncEnable <= 1'b1;
    end else if (cmd.universal && !cmd.powerDown) begin
      asyncEnable <= 1'b0;
    end
  end

  // ============================================================
  // parallel poll configuration
  // unconfigure or an addressed disable beats an enable
  logic [3:0] ppCode_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ppConfigured <= 1'b0;
      ppCode_q     <= 4'h0;
    end else if (cmd.ppUnconfig ||
                 (cmd.ppDisable && listenerAddressed)) begin
      ppConfigured <= 1'b0;
    end else if (cmd.ppEnable) begin
      ppConfigured <= 1'b1;
      ppCode_q     <= cmd.ppCode;
    end
  end

  // ============================================================
  // frame modify
  frame_t    mod;
  id_state_t st_q;
  logic      ppSense;
  logic      frameTake;

  assign ppSense   = ppCode_q[`PPOLL_SENSE_BIT];
  assign frameTake = inValid && (!outValid || outReady);

  always_comb begin
    mod = inFrame;
    if (srq_q && inFrame.kind inside {FR_DATA, FR_END, FR_IDENTIFY}) begin
      mod.srq = 1'b1;
    end
    if (ppConfigured && inFrame.kind == FR_IDENTIFY &&
        (ppSense == srq_q)) begin
      mod.data[ppCode_q[2:0]] = 1'b1;
    end
  end

  // ============================================================
  // outgoing frame register
  // passing frames are taken in every state, so an idle identify in
  // flight never swallows a frame that the loop hands on
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      outFrame <= '0;
      outValid <= 1'b0;
    end else begin
      if (frameTake) begin
        outFrame <= mod;
        outValid <= 1'b1;
      end else if (st_q == ID_IDLE && loopIdle && asyncEnable &&
                   srq_q && !outValid) begin
        outFrame <= '{kind: FR_IDENTIFY, srq: 1'b1,
                      data: 8'h00};
        outValid <= 1'b1;
      end else if (outValid && outReady) begin
        outValid <= 1'b0;
      end
    end
  end

  // ============================================================
  // idle identify sequencer
  // one identify per idle spell: wait for the loop to leave idle
  // or the request to clear before sourcing another
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= ID_IDLE;
    end else begin
      case (st_q)
        ID_IDLE: begin
          if (!frameTake && loopIdle && asyncEnable && srq_q &&
              !outValid) begin
            st_q <= ID_SEND;
          end
        end
        ID_SEND: begin
          if (outReady) begin
            st_q <= ID_WAIT;
          end
        end
        ID_WAIT: begin
          if (!loopIdle || !srq_q) begin
            st_q <= ID_IDLE;
          end
        end
        default: begin
          st_q <= ID_IDLE;
        end
      endcase
    end
  end
endmodule

// file: tb/loop_srq_properties.sv
// port assertions for loop_srq
// bound to every loop_srq instance by the bind at the foot
`timescale 1ns/1ns
`include "loop_srq_cfg.svh"
module loop_srq_properties
  import loop_srq_pkg::*;
(
  input wire logic                   clock,
  input wire logic                   rstn,
  input wire loop_cmd_t              cmd,
  input wire logic                   listenerAddressed,
  input wire logic                   inValid,
  input wire frame_t                 inFrame,
  input wire frame_t                 outFrame,
  input wire logic                   outValid,
  input wire logic                   outReady,
  input wire logic [`COND_COUNT-1:0] requestEnable,
  input wire logic                   asyncEnable,
  input wire logic                   sysStatusSrq,
  input wire logic                   ppConfigured
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic tk;
  assign tk = inValid && (!outValid || outReady);
  property p_hold;
    outValid && !outReady |=> outValid && $stable(outFrame);
  endproperty
  a_hold: assert property (p_hold) else $error("frame moved");
  property p_mark;
    tk && inFrame.kind == FR_DATA && sysStatusSrq |=> outFrame.srq;
  endproperty
  a_mark: assert property (p_mark) else $error("no mark");
  property p_pass;
    tk && inFrame.kind == FR_DATA |=> outFrame.data == $past(inFrame.data);
  endproperty
  a_pass: assert property (p_pass) else $error("data changed");
  property p_asyOff;
    cmd.universal && !cmd.enableAsync && !cmd.powerDown |=> !asyncEnable;
  endproperty
  a_asyOff: assert property (p_asyOff) else $error("async kept");
  property p_asyOn; cmd.enableAsync |=> asyncEnable; endproperty
  a_asyOn: assert property (p_asyOn) else $error("async off");
  property p_ppOff;
    cmd.ppUnconfig || cmd.ppDisable && listenerAddressed |=> !ppConfigured;
  endproperty
  a_ppOff: assert property (p_ppOff) else $error("poll kept");
  property p_ppOn;
    cmd.ppEnable && !cmd.ppUnconfig && !cmd.ppDisable |=> ppConfigured;
  endproperty
  a_ppOn: assert property (p_ppOn) else $error("poll off");
  property p_master; !requestEnable[3] |=> !sysStatusSrq; endproperty
  a_master: assert property (p_master) else $error("srq no master");
endmodule
bind loop_srq loop_srq_properties i_loop_srq_properties (.*);

// file: tb/loop_ctrl_model.sv
// far-side loop controller model: takes outgoing frames
// slow high makes it stall at random
`timescale 1ns/1ns
module loop_ctrl_model (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic slow,
  output logic      outReady
);
  // takes identify frames alike whatever their origin
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) outReady <= 1'b0;
    else outReady <= !slow || 1'($urandom_range(1));
  end
endmodule

// file: tb/loop_srq_tb.sv
// self-checking bench for loop_srq
// inputs change at the falling edge; frames checked from a queue
`timescale 1ns/1ns
`include "loop_srq_cfg.svh"
module loop_srq_tb;
  import loop_srq_pkg::*;
  logic        clock = 0, rstn = 0, key = 0, enWrite = 0;
  logic        inValid = 0, slow = 0, idle = 0, lsn = 0;
  logic        outValid, outReady, asy, srq, ppc;
  logic [23:0] cond = 0, enData = 0, reqEn;
  logic [7:0]  d;
  loop_cmd_t   cmd = '0;
  frame_t      inFrame = '0, outFrame;
  frame_t      q[$];
  int          fails = 0, checked = 0;
  loop_srq i_loop_srq (.clock, .rstn, .switchOpen(1'b1),
    .manualRequestKey(key), .statusCond(cond), .enWrite,
    .enWriteData(enData), .cmd, .listenerAddressed(lsn),
    .loopIdle(idle), .inValid, .inFrame, .outFrame, .outValid,
    .outReady, .requestEnable(reqEn), .asyncEnable(asy),
    .sysStatusSrq(srq), .ppConfigured(ppc));
  loop_ctrl_model i_loop_ctrl_model (.clock, .rstn, .slow, .outReady);
  initial forever #20 clock = ~clock;
  task automatic chk(logic [23:0] got, logic [23:0] want);
    checked++;
    if (got !== want) begin
      fails++;
      $display("wrong value t=%0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic summarize;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic send(frame_kind_t k, logic [7:0] v, logic s, logic [7:0] e);
    @(negedge clock);
    while (outValid && !outReady) @(negedge clock);
    inFrame = '{k, 1'b0, v};
    inValid = 1;
    q.push_back('{k, s, e});
    @(negedge clock);
    inValid = 0;
  endtask
  task automatic pulse(logic [10:0] c);
    @(negedge clock) cmd = loop_cmd_t'(c);
    @(negedge clock) cmd = '0;
  endtask
  task automatic press;
    @(negedge clock) key = 1;
    @(negedge clock) key = 0;
    repeat (2) @(negedge clock);
  endtask
  task automatic wr(logic [23:0] v);
    @(negedge clock) begin enWrite = 1; enData = v; end
    @(negedge clock) enWrite = 0;
  endtask
  task automatic drain;
    for (int i = 0; i < 80 && q.size() > 0; i++) @(negedge clock);
  endtask
  always @(posedge clock)
    if (outValid && outReady) begin
      if (q.size() == 0) chk(24'h1, 24'h0);
      else chk(outFrame, q.pop_front());
    end
  initial begin #400000; fails++; summarize(); end
  initial begin
    void'($urandom(32'hd2cc));
    repeat (20) @(negedge clock);
    rstn = 1;
    repeat (3) @(negedge clock);
    chk(reqEn, `OPEN_DEFAULT);
    slow = 1;
    repeat (4) begin d = $urandom; send(FR_DATA, d, 0, d); end
    press();
    chk(srq, 1);
    send(FR_END, 8'h5a, 1, 8'h5a);
    send(FR_DATA, 8'ha5, 1, 8'ha5);
    pulse(11'h001);
    chk(srq, 0);
    for (int s = 0; s < 2; s++) begin
      if (s) press();
      for (int c = 0; c < 16; c++) begin
        pulse({4'h1, c[3:0], 3'h0});
        chk(ppc, 1);
        d = $urandom;
        send(FR_IDENTIFY, d, s[0],
          d | (c[3] == s[0] ? 8'h01 << c[2:0] : 8'h00));
      end
    end
    lsn = 1;
    pulse(11'h002);
    chk(ppc, 0);
    send(FR_IDENTIFY, 8'h3c, 1, 8'h3c);
    drain();
    pulse(11'h200);
    q.push_back('{FR_IDENTIFY, 1'b1, 8'h00});
    idle = 1;
    drain();
    idle = 0;
    pulse(11'h500);
    chk(asy, 1);
    pulse(11'h404);
    chk(asy, 0);
    pulse(11'h001);
    wr($urandom & 24'hfff7f7);
    chk(reqEn, enData);
    press();
    chk(srq, 0);
    wr(24'h000808);
    cond = 24'h000800;
    repeat (3) @(negedge clock);
    chk(srq, 1);
    drain();
    chk(24'(q.size()), 24'h0);
    summarize();
  end
endmodule
